// *** serom_regs.svh ***
// Register map, field positions and timing figures of the serial ROM command block.
// Included by the package and by every design file; definitions only.
`ifndef SEROM_REGS_SVH
`define SEROM_REGS_SVH
`define SEROM_OFS_CMD       8'hB0
`define SEROM_OFS_DATA      8'hB4
`define SEROM_BUSY_BIT      31
`define SEROM_OP_HI         30
`define SEROM_OP_LO         28
`define SEROM_TOUT_BIT      9
`define SEROM_ADDR_HI       7
`define SEROM_BUSY_RST      1'b1
`define SEROM_CLK_MHZ       50
`define SEROM_TIMEOUT_US    30000
`define SEROM_TIMEOUT_CYC   (`SEROM_TIMEOUT_US * `SEROM_CLK_MHZ)
`define SEROM_HALF_CYC      10
`define SEROM_ADDR_W        7
`define SEROM_STATION_BYTES 6
`define SEROM_SIGNATURE     8'h5C // Arbitrary value
`endif

// *** serom_pkg.sv ***
// Types shared by the serial ROM command block and its shift engine.
// Assumes serom_regs.svh is on the include path.
`default_nettype none
`include "serom_regs.svh"
package serom_pkg;
  typedef enum logic [2:0] {
    SEROM_OP_READ  = 3'h0,
    SEROM_OP_EWDS  = 3'h1,
    SEROM_OP_EWEN  = 3'h2,
    SEROM_OP_WRITE = 3'h3,
    SEROM_OP_WRAL  = 3'h4
  } serom_op_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } serom_apb_req_t;

  typedef struct packed {
    logic cs;
    logic sk;
    logic dout;
  } serom_pins_t;

  typedef enum logic [2:0] {
    SEROM_C_IDLE   = 3'b001,
    SEROM_C_LAUNCH = 3'b010,
    SEROM_C_WAIT   = 3'b100
  } serom_ctl_state_t;

  typedef enum logic [3:0] {
    SEROM_E_IDLE  = 4'b0001,
    SEROM_E_SHIFT = 4'b0010,
    SEROM_E_GAP   = 4'b0100,
    SEROM_E_POLL  = 4'b1000
  } serom_eng_state_t;
endpackage
`default_nettype wire

// *** serom_shift.sv ***
// Three-wire serial ROM shift engine: sends a frame MSB first, reads bytes back,
// and optionally polls the ready level with a timeout.
// Assumes start is a one-cycle pulse given only while the engine is idle.
`timescale 1ns/1ps
`default_nettype none
`include "serom_regs.svh"
module serom_shift
#(
  parameter int FRAME_W     = 3 + `SEROM_ADDR_W + 8,
  parameter int HALF_CYC    = `SEROM_HALF_CYC,
  parameter int TIMEOUT_CYC = `SEROM_TIMEOUT_CYC
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  ce,
  input  wire logic                  start,
  input  wire logic [FRAME_W-1:0]    frame,
  input  wire logic [4:0]            n_out,
  input  wire logic [4:0]            n_in,
  input  wire logic                  wait_ready,
  input  wire logic                  rom_rx,
  output serom_pkg::serom_pins_t     rom_pins,
  output logic                       done,
  output logic                       timed_out,
  output logic [7:0]                 rdata
);
  import serom_pkg::*;
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int HW = $clog2(HALF_CYC + 1);

  serom_eng_state_t   state, next_state;
  logic [FRAME_W-1:0] sh, next_sh;
  logic [4:0]         cnt, next_cnt;
  logic [HW-1:0]      div, next_div;
  logic [TW-1:0]      tmo, next_tmo;
  logic [7:0]         next_rdata;
  logic               wr_wait, next_wr_wait;
  logic               next_done, next_timed_out;
  serom_pins_t        next_pins;
  logic               rx_meta, rx_sync;
  logic               tick;

  // Pin from the ROM is asynchronous to clk_sys
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
    end
    else if (ce)
    begin
      rx_meta <= rom_rx;
      rx_sync <= rx_meta;
    end
  end

  assign tick = (div == HW'(HALF_CYC - 1));

  always_comb
  begin
    next_state     = state;
    next_sh        = sh;
    next_cnt       = cnt;
    next_div       = tick ? '0 : div + 1'b1;
    next_tmo       = tmo;
    next_rdata     = rdata;
    next_wr_wait   = wr_wait;
    next_done      = 1'b0;
    next_timed_out = timed_out;
    next_pins      = rom_pins;
    case (state)
      SEROM_E_IDLE:
      begin
        next_div = '0;
        if (start)
        begin
          next_sh        = frame;
          next_cnt       = n_out + n_in;
          next_wr_wait   = wait_ready;
          next_timed_out = 1'b0;
          next_pins      = '{cs: 1'b1, sk: 1'b0, dout: frame[FRAME_W-1]};
          next_state     = SEROM_E_SHIFT;
        end
      end
      SEROM_E_SHIFT:
        if (tick && !rom_pins.sk)
        begin
          next_pins.sk = 1'b1;
          if (cnt <= n_in)
            next_rdata = {rdata[6:0], rx_sync};
        end
        else if (tick)
        begin
          next_pins.sk   = 1'b0;
          next_sh        = {sh[FRAME_W-2:0], 1'b0};
          next_pins.dout = sh[FRAME_W-2];
          next_cnt       = cnt - 1'b1;
          if (cnt == 5'h01)
          begin
            next_pins  = '{cs: 1'b0, sk: 1'b0, dout: 1'b0};
            next_state = SEROM_E_GAP;
          end
        end
      SEROM_E_GAP:
        if (tick && wr_wait)
        begin
          // Raising select again shows the ROM's ready level on its output
          next_pins.cs = 1'b1;
          next_tmo     = '0;
          next_state   = SEROM_E_POLL;
        end
        else if (tick)
        begin
          next_done  = 1'b1;
          next_state = SEROM_E_IDLE;
        end
      SEROM_E_POLL:
      begin
        next_tmo = tmo + 1'b1;
        if (rx_sync || tmo == TW'(TIMEOUT_CYC - 1))
        begin
          next_timed_out = !rx_sync;
          next_done      = 1'b1;
          next_pins.cs   = 1'b0;
          next_state     = SEROM_E_IDLE;
        end
      end
      default:
        next_state = SEROM_E_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state     <= SEROM_E_IDLE;
      sh        <= '0;
      cnt       <= '0;
      div       <= '0;
      tmo       <= '0;
      rdata     <= '0;
      wr_wait   <= 1'b0;
      done      <= 1'b0;
      timed_out <= 1'b0;
      rom_pins  <= '0;
    end
    else if (ce)
    begin
      state     <= next_state;
      sh        <= next_sh;
      cnt       <= next_cnt;
      div       <= next_div;
      tmo       <= next_tmo;
      rdata     <= next_rdata;
      wr_wait   <= next_wr_wait;
      done      <= next_done;
      timed_out <= next_timed_out;
      rom_pins  <= next_pins;
    end
  end

  timeout_ends_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && state == SEROM_E_POLL && tmo == TW'(TIMEOUT_CYC - 1) && !rx_sync |=> done && timed_out)
    else $error("poll timeout did not end the operation");
  select_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    state == SEROM_E_IDLE && !$past(done) |-> !rom_pins.cs)
    else $error("chip select high while engine idle");
endmodule // serom_shift
`default_nettype wire

// *** serom_ctrl.sv ***
// Serial ROM command block: APB register slave, command launch, busy handshake
// and the automatic station address fetch after reset.
// Assumes an APB master on clk_sys and a three-wire serial ROM on the pins.
//
// Functional notes
// - Writing busy one launches selected command
// - Busy holds through operation, then self-clears
// - Read data valid once busy clears
// - Missing ROM write ends at timeout
// - Busy reads one right after reset
// - Station address fetched after reset, then clear
// - Three-bit command acted on only when busy
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "serom_regs.svh"
module serom_ctrl
#(
  parameter int         ADDR_W      = `SEROM_ADDR_W,
  parameter int         TIMEOUT_CYC = `SEROM_TIMEOUT_CYC,
  parameter int         HALF_CYC    = `SEROM_HALF_CYC,
  parameter logic [7:0] SIGNATURE   = `SEROM_SIGNATURE // Arbitrary value
)
(
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic                    ce,
  input  wire serom_pkg::serom_apb_req_t apb,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire logic                    rom_rx,
  output serom_pkg::serom_pins_t       rom_pins,
  output logic [47:0]                  station_addr,
  output logic                         station_addr_valid
);
  import serom_pkg::*;
  localparam int FRAME_W = 3 + ADDR_W + 8;

  serom_ctl_state_t   state, next_state;
  logic               busy, next_busy;
  logic               boot, next_boot;
  logic [2:0]         op, next_op;
  logic [7:0]         addr, next_addr;
  logic [7:0]         data, next_data;
  logic               tout, next_tout;
  logic [2:0]         bidx, next_bidx;
  logic [47:0]        next_station;
  logic               next_valid;
  logic [31:0]        next_prdata;
  logic               next_pslverr;
  logic               start, eng_done, eng_to;
  logic [7:0]         eng_rdata;
  logic [FRAME_W-1:0] frame;
  logic [4:0]         n_out, n_in;
  logic               wait_ready;
  logic               wr_acc, setup;

  function automatic logic op_defined(input logic [2:0] code);
    op_defined = (code <= SEROM_OP_WRAL);
  endfunction

  // Frame left aligned: start bit, two opcode bits, address, optional data
  always_comb
  begin
    frame      = '0;
    n_out      = 5'(3 + ADDR_W);
    n_in       = 5'h00;
    wait_ready = 1'b0;
    case (boot ? SEROM_OP_READ : op)
      SEROM_OP_READ:
      begin
        frame[FRAME_W-1 -: 3 + ADDR_W] = {3'b110, boot ? ADDR_W'(bidx) : addr[ADDR_W-1:0]};
        n_in = 5'h08;
      end
      SEROM_OP_EWDS:
        frame[FRAME_W-1 -: 5] = 5'b10000;
      SEROM_OP_EWEN:
        frame[FRAME_W-1 -: 5] = 5'b10011;
      SEROM_OP_WRITE:
      begin
        frame      = {3'b101, addr[ADDR_W-1:0], data};
        n_out      = 5'(FRAME_W);
        wait_ready = 1'b1;
      end
      SEROM_OP_WRAL:
      begin
        frame      = {5'b10001, {(ADDR_W-2){1'b0}}, data};
        n_out      = 5'(FRAME_W);
        wait_ready = 1'b1;
      end
      default:
        n_out = 5'h00;
    endcase
  end

  assign pready = apb.psel & apb.penable & ce;
  assign setup  = apb.psel & ~apb.penable;
  assign wr_acc = pready & apb.pwrite;
  assign start  = ce & (state == SEROM_C_LAUNCH) & (boot | op_defined(op));

  always_comb
  begin
    next_state   = state;
    next_busy    = busy;
    next_boot    = boot;
    next_op      = op;
    next_addr    = addr;
    next_data    = data;
    next_tout    = tout;
    next_bidx    = bidx;
    next_station = station_addr;
    next_valid   = station_addr_valid;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup)
    begin
      next_pslverr = 1'b0;
      case (apb.paddr)
        `SEROM_OFS_CMD:
          next_prdata = {busy, op, 18'h00000, tout, 1'b0, addr};
        `SEROM_OFS_DATA:
          next_prdata = {24'h000000, data};
        default:
        begin
          next_prdata  = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    case (state)
      SEROM_C_IDLE:
        // Writes while busy are dropped so a running operation stays intact
        if (wr_acc && !busy && apb.paddr == `SEROM_OFS_CMD && apb.pwdata[`SEROM_BUSY_BIT])
        begin
          next_op    = apb.pwdata[`SEROM_OP_HI:`SEROM_OP_LO];
          next_addr  = apb.pwdata[`SEROM_ADDR_HI:0];
          next_busy  = 1'b1;
          next_tout  = 1'b0;
          next_state = SEROM_C_LAUNCH;
        end
        else if (wr_acc && !busy && apb.paddr == `SEROM_OFS_DATA)
          next_data = apb.pwdata[7:0];
      SEROM_C_LAUNCH:
        if (boot || op_defined(op))
          next_state = SEROM_C_WAIT;
        else
        begin
          next_busy  = 1'b0;
          next_state = SEROM_C_IDLE;
        end
      SEROM_C_WAIT:
        if (eng_done && boot)
        begin
          if (bidx != 3'h0)
            next_station[{bidx - 3'h1, 3'b000} +: 8] = eng_rdata;
          // Blank or absent ROM still ends the fetch and frees the host
          if (eng_to || (bidx == 3'h0 && eng_rdata != SIGNATURE) || bidx == 3'(`SEROM_STATION_BYTES))
          begin
            next_valid = (bidx == 3'(`SEROM_STATION_BYTES));
            next_boot  = 1'b0;
            next_busy  = 1'b0;
            next_state = SEROM_C_IDLE;
          end
          else
          begin
            next_bidx  = bidx + 3'h1;
            next_state = SEROM_C_LAUNCH;
          end
        end
        else if (eng_done)
        begin
          if (op == SEROM_OP_READ)
            next_data = eng_rdata;
          next_tout  = eng_to;
          next_busy  = 1'b0;
          next_state = SEROM_C_IDLE;
        end
      default:
        next_state = SEROM_C_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state              <= SEROM_C_LAUNCH;
      busy               <= `SEROM_BUSY_RST;
      boot               <= 1'b1;
      op                 <= 3'h0;
      addr               <= 8'h00;
      data               <= 8'h00;
      tout               <= 1'b0;
      bidx               <= 3'h0;
      station_addr       <= 48'h000000000000;
      station_addr_valid <= 1'b0;
      prdata             <= 32'h00000000;
      pslverr            <= 1'b0;
    end
    else if (ce)
    begin
      state              <= next_state;
      busy               <= next_busy;
      boot               <= next_boot;
      op                 <= next_op;
      addr               <= next_addr;
      data               <= next_data;
      tout               <= next_tout;
      bidx               <= next_bidx;
      station_addr       <= next_station;
      station_addr_valid <= next_valid;
      prdata             <= next_prdata;
      pslverr            <= next_pslverr;
    end
  end

  serom_shift
  #(
    .FRAME_W     (FRAME_W),
    .HALF_CYC    (HALF_CYC),
    .TIMEOUT_CYC (TIMEOUT_CYC)
  )
  u_shift
  (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .ce         (ce),
    .start      (start),
    .frame      (frame),
    .n_out      (n_out),
    .n_in       (n_in),
    .wait_ready (wait_ready),
    .rom_rx     (rom_rx),
    .rom_pins   (rom_pins),
    .done       (eng_done),
    .timed_out  (eng_to),
    .rdata      (eng_rdata)
  );

  busy_at_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(reset) |-> busy && boot)
    else $error("busy not set after reset");
  cmd_launch_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && state == SEROM_C_IDLE && !busy && wr_acc && apb.paddr == `SEROM_OFS_CMD && apb.pwdata[`SEROM_BUSY_BIT]
    |=> busy && state == SEROM_C_LAUNCH && op == $past(apb.pwdata[`SEROM_OP_HI:`SEROM_OP_LO]))
    else $error("command write did not launch");
  busy_holds_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && busy && state == SEROM_C_WAIT && !eng_done |=> busy)
    else $error("busy dropped mid operation");
  done_clears_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && state == SEROM_C_WAIT && eng_done && !boot |=> !busy && tout == $past(eng_to))
    else $error("busy not cleared on completion");
  read_data_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && state == SEROM_C_WAIT && eng_done && !boot && op == SEROM_OP_READ |=> data == $past(eng_rdata))
    else $error("read data not loaded at completion");
  busy_write_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && busy && wr_acc |=> $stable(op) && $stable(addr) && $stable(data))
    else $error("register changed by write while busy");
  noop_code_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && state == SEROM_C_LAUNCH && !boot && !op_defined(op) |-> !start ##1 !busy)
    else $error("undefined command not treated as no-op");
  boot_start_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(reset) && ce |-> start ##1 state == SEROM_C_WAIT && busy)
    else $error("station fetch did not start after reset");
endmodule // serom_ctrl
`default_nettype wire

// *** serom_rom_model.sv ***
// Behavioural three-wire serial ROM facing the command block's pins.
// Assumes frames of start, 2-bit opcode, 7-bit address, MSB first, sampled at sk rise.
`timescale 1ns/1ps
`default_nettype none
module serom_rom_model
#(
  parameter logic [7:0] SIG = 8'h3A // Arbitrary value
)
(
  input  wire logic                   clk_sys,
  input  wire logic                   present,
  input  wire logic [15:0]            wr_cyc,
  input  wire serom_pkg::serom_pins_t rom_pins,
  output logic                        rom_rx
);
  import serom_pkg::*;
  logic [7:0] mem [0:127];
  logic [6:0] addr;
  logic       prev_sk;
  int         nbits;
  int         since_cs;

  initial
  begin
    addr = 7'h00;
    prev_sk = 1'b0;
    nbits = 0;
    since_cs = 0;
    for (int i = 0; i < 128; i++)
      mem[i] = (i == 0) ? SIG : (8'(i) ^ 8'hC3);
  end

  always @(posedge clk_sys)
  begin
    prev_sk <= rom_pins.sk;
    if (!rom_pins.cs)
    begin
      nbits <= 0;
      since_cs <= 0;
    end
    else
    begin
      since_cs <= since_cs + 1;
      if (rom_pins.sk && !prev_sk)
      begin
        nbits <= nbits + 1;
        if (nbits >= 3 && nbits < 10)
          addr <= {addr[5:0], rom_pins.dout};
      end
    end
  end

  // Data line pulled low when deselected or absent, so a missing part never looks ready
  always_comb
  begin
    if (!present || !rom_pins.cs)
      rom_rx = 1'b0;
    else if (nbits >= 10 && nbits < 18)
      rom_rx = mem[addr][17 - nbits];
    else
      rom_rx = (since_cs >= int'(wr_cyc));
  end
endmodule // serom_rom_model
`default_nettype wire

// *** serom_tb.sv ***
// Self-checking bench for the serial ROM command block over APB.
// Assumes serom_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import serom_pkg::*;
  localparam logic [7:0] SIG = 8'h3A; // Arbitrary value
  logic           clk_sys = 1'b0;
  logic           reset = 1'b1;
  logic           ce = 1'b1;
  logic           present = 1'b1;
  logic [15:0]    wr_cyc = 16'h0004;
  serom_apb_req_t apb = '0;
  logic           pready;
  logic           pslverr;
  logic           station_addr_valid;
  logic           rom_rx;
  logic [31:0]    prdata;
  logic [31:0]    rd;
  logic           err;
  logic [47:0]    station_addr;
  serom_pins_t    rom_pins;
  logic           cs_q = 1'b0;
  int             n_fail = 0;
  int             compares = 0;
  int             cs_starts = 0;
  int             cyc;

  serom_ctrl #(.TIMEOUT_CYC(200), .HALF_CYC(4), .SIGNATURE(SIG)) i_serom_ctrl (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .apb(apb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rom_rx(rom_rx), .rom_pins(rom_pins), .station_addr(station_addr),
    .station_addr_valid(station_addr_valid));
  serom_rom_model #(.SIG(SIG)) i_serom_rom_model (
    .clk_sys(clk_sys), .present(present), .wr_cyc(wr_cyc), .rom_pins(rom_pins), .rom_rx(rom_rx));

  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    cs_q <= rom_pins.cs;
    if (rom_pins.cs === 1'b1 && cs_q === 1'b0)
      cs_starts++;
  end

  function automatic logic [7:0] rom_byte(input int a);
    return (a == 0) ? SIG : (8'(a) ^ 8'hC3);
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apb.penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1);
    check(n, 1, "wait states");
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  task automatic cmd(input logic [2:0] op, input logic [7:0] a);
    xfer(1'b1, 8'hB0, {1'b1, op, 20'h00000, a});
  endtask

  // Polls busy; cycle count comes back in cyc
  task automatic wait_idle(input int lim);
    cyc = 0;
    do
    begin
      xfer(1'b0, 8'hB0, 32'h0);
      cyc += 3;
    end
    while (rd[31] !== 1'b0 && cyc < lim);
    check(rd[31], 1'b0, "busy stuck");
    if (rd[31] !== 1'b0)
      summarize();
  endtask

  task automatic t_boot(input logic good);
    logic [47:0] exp;
    for (int k = 0; k < 6; k++)
      exp[8*k +: 8] = good ? rom_byte(k + 1) : 8'h00;
    xfer(1'b0, 8'hB0, 32'h0);
    check(rd[31], 1'b1, "busy after reset");
    check(station_addr_valid, 1'b0, "valid early");
    wait_idle(3000);
    check(station_addr_valid, good, "fetch valid");
    check(station_addr, exp, "station bytes");
  endtask

  task automatic t_read(input logic [7:0] a);
    cmd(3'h0, a);
    xfer(1'b0, 8'hB0, 32'h0);
    check(rd[31], 1'b1, "busy during read");
    check(rd[30:28], 3'h0, "op field");
    wait_idle(1000);
    check(rd[6:0], a[6:0], "addr field");
    xfer(1'b0, 8'hB4, 32'h0);
    check(rd, {24'h0, rom_byte(int'(a[6:0]))}, "read data");
    check(err, 1'b0, "mapped error");
  endtask

  task automatic t_nop();
    int n;
    for (int op = 5; op < 8; op++)
    begin
      n = cs_starts;
      cmd(3'(op), 8'h11);
      wait_idle(30);
      check(cs_starts, n, "pins moved on no-op");
    end
    n = cs_starts;
    xfer(1'b1, 8'hB0, {1'b0, 3'h0, 20'h00000, 8'h12});
    xfer(1'b0, 8'hB0, 32'h0);
    check(rd[31], 1'b0, "start without busy");
    repeat (20) @(posedge clk_sys);
    check(cs_starts, n, "pins moved without busy");
  endtask

  task automatic t_ops();
    present <= 1'b1;
    wr_cyc <= 16'h003C;
    for (int op = 1; op < 5; op++)
    begin
      xfer(1'b1, 8'hB4, 32'h000000A5);
      cmd(3'(op), 8'h22);
      wait_idle(300);
      check(rd[9], 1'b0, "timeout with rom present");
    end
  endtask

  task automatic t_absent();
    present <= 1'b0;
    xfer(1'b1, 8'hB4, 32'h0000005A);
    cmd(3'h3, 8'h23);
    repeat (300) @(posedge clk_sys);
    xfer(1'b0, 8'hB0, 32'h0);
    check(rd[31], 1'b1, "busy before timeout");
    wait_idle(400);
    check(rd[9], 1'b1, "timeout flag");
    present <= 1'b1;
  endtask

  task automatic t_refuse();
    cmd(3'h0, 8'h03);
    xfer(1'b1, 8'hB4, 32'h000000FF);
    cmd(3'h0, 8'h04);
    wait_idle(1000);
    check(rd[6:0], 7'h03, "second command taken");
    xfer(1'b0, 8'hB4, 32'h0);
    check(rd, {24'h0, rom_byte(3)}, "data overwritten while busy");
  endtask

  task automatic t_unmapped();
    xfer(1'b0, 8'hC0, 32'h0);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
  endtask

  // Clock enable low in mid-read must freeze the pins, and the read still completes
  task automatic t_freeze();
    serom_pins_t p;
    cmd(3'h0, 8'h09);
    repeat (30) @(posedge clk_sys);
    ce <= 1'b0;
    @(posedge clk_sys);
    p = rom_pins;
    repeat (20) @(posedge clk_sys);
    check(rom_pins, p, "pins moved with ce low");
    ce <= 1'b1;
    wait_idle(1000);
    xfer(1'b0, 8'hB4, 32'h0);
    check(rd, {24'h0, rom_byte(9)}, "read data after freeze");
  endtask

  task automatic t_reset(input logic good);
    present <= good;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_boot(good);
    present <= 1'b1;
  endtask

  task automatic summarize();
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    t_boot(1'b1);
    t_read(8'h05);
    t_read(8'h7F);
    t_nop();
    t_ops();
    t_absent();
    t_refuse();
    t_unmapped();
    t_freeze();
    // Reset again in mid-run: busy and the fetch restart, also with no ROM fitted
    t_reset(1'b1);
    t_reset(1'b0);
    summarize();
  end

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end
endmodule // tb
`default_nettype wire
